// *** common/can_rx_flags_pkg.sv ***
// Purpose: Shared constants for the receiver flag and bus-state block
// Assumes: 8-bit and 3-bit registers in the low bits of 32-bit Wishbone words
// Notes:   Offsets are byte addresses
package can_rx_flags_pkg;
  localparam logic [7:0] flags_offset      = 8'h00;
  localparam logic [7:0] enables_offset    = 8'h04;
  localparam logic [7:0] control_offset    = 8'h08;
  localparam logic [7:0] irq_status_offset = 8'h0C;
  localparam logic [7:0] irq_mask_offset   = 8'h10;

  localparam int wakeup_bit    = 7;
  localparam int status_bit    = 6;
  localparam int overrun_bit   = 1;
  localparam int full_bit      = 0;
  localparam int wakeup_enable_bit      = 0;
  localparam int init_rq_bit   = 1;
  localparam int init_ak_bit   = 2;
  localparam int sleep_ak_bit  = 3;

  localparam logic [7:0] flags_reset   = 8'h00;
  localparam logic [7:0] enables_reset = 8'h00;
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [2:0] irq_reset     = 3'h0;

  localparam logic [8:0] warn_limit    = 9'h060;
  localparam logic [8:0] err_limit     = 9'h07F;
  localparam logic [8:0] busoff_limit  = 9'h0FF;

  typedef enum logic [1:0] {
    st_ok      = 2'b00,
    st_warning = 2'b01,
    st_error   = 2'b10,
    st_bus_off = 2'b11
  } bus_state_type;
endpackage : can_rx_flags_pkg

// *** rtl/can_rx_flags.sv ***
// Purpose: Receiver flags, bus-state fields and interrupt requests
// Assumes: Protocol engine inputs are on clk_i; bus_activity_i is a pin
// Notes:   Interrupt status bits are wakeup, error, receive (bits 2:0)
// Function
// - Flags cleared by writing one, condition gone
// - Init mode holds flag register reset
// - Bus-state fields survive initialization mode
// - Zero writes ignored; state fields read-only
// - Sleep bus activity sets wakeup flag
// - Enabled flags keep their interrupt pending
// - Bus-state change sets status change flag
// - State fields frozen while status flag set
// - Receiver state encoded from error counters
// - Transmitter state derived from error counters
// - Overrun event sets overrun flag
// - Good message shift sets buffer full
// - Full flag blocks foreground buffer shift
// - Bus-off forces receiver bus-off, then ok
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module can_rx_flags (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [8:0]  tx_err_count_i,
  input  wire logic [7:0]  rx_err_count_i,
  input  wire logic        bus_activity_i,
  input  wire logic        overrun_event_i,
  input  wire logic        msg_good_i,
  input  wire logic        fifo_not_empty_i,
  output logic             shift_foreground_o,
  output logic             wakeup_irq_o,
  output logic             error_irq_o,
  output logic             receive_irq_o,
  output logic             irq_o
);
  import can_rx_flags_pkg::*;

  logic [7:0] flags, next_flags;
  logic [7:0] enables, next_enables;
  logic [7:0] control, next_control;
  logic [1:0] rx_state, next_rx_state;
  logic [1:0] tx_state, next_tx_state;
  logic [2:0] irq_status, next_irq_status;
  logic [2:0] irq_mask, next_irq_mask;
  logic [31:0] next_dat;
  logic       next_ack, next_shift, next_irq;
  logic       act_meta, act_sync, act_prev;
  logic       init_mode, wr, rd;
  logic [1:0] rx_calc, tx_calc, rx_target;
  logic [2:0] irq_events;

  // Receiver state from counters; bus-off overrides
  function automatic logic [1:0] rx_code(input logic [8:0] tec, input logic [7:0] rec);
    if (tec > busoff_limit) rx_code = st_bus_off;
    else if ({1'b0, rec} > err_limit) rx_code = st_error;
    else if ({1'b0, rec} > warn_limit) rx_code = st_warning;
    else rx_code = st_ok;
  endfunction : rx_code

  // Transmitter state uses the same thresholds on TEC
  function automatic logic [1:0] tx_code(input logic [8:0] tec);
    if (tec > busoff_limit) tx_code = st_bus_off;
    else if (tec > err_limit) tx_code = st_error;
    else if (tec > warn_limit) tx_code = st_warning;
    else tx_code = st_ok;
  endfunction : tx_code

  // Pin synchroniser; second stage and its delayed copy form the edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_meta <= 1'b0;
      act_sync <= 1'b0;
      act_prev <= 1'b0;
    end else begin
      act_meta <= bus_activity_i;
      act_sync <= act_meta;
      act_prev <= act_sync;
    end
  end

  assign init_mode  = control[init_rq_bit] & control[init_ak_bit];
  assign wr         = cyc_i & stb_i & we_i & sel_i[0] & ~ack_o;
  assign rd         = cyc_i & stb_i & ~ack_o;
  assign rx_calc    = rx_code(tx_err_count_i, rx_err_count_i);
  assign tx_calc    = tx_code(tx_err_count_i);
  // Bus-off exit skips the receiver to ok, even with REC still high
  assign rx_target  = (rx_state == st_bus_off && tx_calc != st_bus_off) ? st_ok : rx_calc;

  always_comb begin
    next_flags      = flags;
    next_enables    = enables;
    next_control    = control;
    next_rx_state   = rx_state;
    next_tx_state   = tx_state;
    next_irq_status = irq_status;
    next_irq_mask   = irq_mask;
    next_shift      = 1'b0;
    // Fields update only while no status change is pending
    if (!flags[status_bit]) begin
      next_rx_state = rx_target;
      next_tx_state = tx_calc;
      if (rx_target != rx_state || tx_calc != tx_state)
        next_flags[status_bit] = 1'b1;
    end
    // Clears first, so a same-cycle set wins
    if (wr && adr_i == flags_offset && !init_mode) begin
      if (dat_i[wakeup_bit] && !(control[sleep_ak_bit] && act_sync && !act_prev))
        next_flags[wakeup_bit] = 1'b0;
      if (dat_i[status_bit] && flags[status_bit])
        next_flags[status_bit] = 1'b0;
      if (dat_i[overrun_bit] && !overrun_event_i)
        next_flags[overrun_bit] = 1'b0;
      if (dat_i[full_bit])
        next_flags[full_bit] = 1'b0;
    end
    if (control[sleep_ak_bit] && control[wakeup_enable_bit] && act_sync && !act_prev)
      next_flags[wakeup_bit] = 1'b1;
    if (overrun_event_i)
      next_flags[overrun_bit] = 1'b1;
    // Shift only while the foreground buffer is free
    if (!flags[full_bit] && fifo_not_empty_i && msg_good_i && !init_mode) begin
      next_shift = 1'b1;
      next_flags[full_bit] = 1'b1;
    end
    next_flags[5:2] = {next_rx_state, next_tx_state};
    // Flags back to reset, state fields keep running
    if (init_mode) begin
      next_flags   = {flags_reset[7:6], next_rx_state, next_tx_state, flags_reset[1:0]};
      next_enables = {enables_reset[7:6], enables[5:2], enables_reset[1:0]};
    end else if (wr && adr_i == enables_offset) begin
      next_enables = dat_i[7:0];
    end
    if (wr && adr_i == control_offset)
      next_control = dat_i[7:0];
    if (wr && adr_i == irq_mask_offset)
      next_irq_mask = dat_i[2:0];
    if (wr && adr_i == irq_status_offset)
      next_irq_status = irq_status & ~dat_i[2:0];
    next_irq_status = next_irq_status | irq_events;
    next_irq        = |(next_irq_status & irq_mask);
  end

  // Pending requests per flag and enable
  assign irq_events = {flags[wakeup_bit] & enables[wakeup_bit],
                       (flags[status_bit] & enables[status_bit]) |
                       (flags[overrun_bit] & enables[overrun_bit]),
                       flags[full_bit] & enables[full_bit]};

  always_comb begin
    next_dat = 32'h0000_0000;
    next_ack = rd;
    unique case (adr_i)
      flags_offset:      next_dat = {24'h00_0000, flags};
      enables_offset:    next_dat = {24'h00_0000, enables};
      control_offset:    next_dat = {24'h00_0000, control};
      irq_status_offset: next_dat = {29'h0000_0000, irq_status};
      irq_mask_offset:   next_dat = {29'h0000_0000, irq_mask};
      default:           next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags              <= flags_reset;
      enables            <= enables_reset;
      control            <= control_reset;
      rx_state           <= st_ok;
      tx_state           <= st_ok;
      irq_status         <= irq_reset;
      irq_mask           <= irq_reset;
      dat_o              <= 32'h0000_0000;
      ack_o              <= 1'b0;
      shift_foreground_o <= 1'b0;
      wakeup_irq_o       <= 1'b0;
      error_irq_o        <= 1'b0;
      receive_irq_o      <= 1'b0;
      irq_o              <= 1'b0;
    end else begin
      flags              <= next_flags;
      enables            <= next_enables;
      control            <= next_control;
      rx_state           <= next_rx_state;
      tx_state           <= next_tx_state;
      irq_status         <= next_irq_status;
      irq_mask           <= next_irq_mask;
      dat_o              <= next_dat;
      ack_o              <= next_ack;
      shift_foreground_o <= next_shift;
      wakeup_irq_o       <= irq_events[2];
      error_irq_o        <= irq_events[1];
      receive_irq_o      <= irq_events[0];
      irq_o              <= next_irq;
    end
  end

  chk_frozen_fields: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(flags[status_bit]) && flags[status_bit] |-> $stable(flags[5:2]))
    else $error("bus-state fields moved while status flag set");
  chk_status_set: assert property (@(posedge clk_i) disable iff (rst_i)
    !flags[status_bit] && !init_mode && (rx_calc != rx_state) |=> flags[status_bit] || init_mode)
    else $error("state change did not set status flag");
  chk_busoff_code: assert property (@(posedge clk_i) disable iff (rst_i)
    !flags[status_bit] && tx_err_count_i > busoff_limit |=> flags[5:4] == 2'b11)
    else $error("bus-off not shown in receiver state");
  chk_full_block: assert property (@(posedge clk_i) disable iff (rst_i)
    flags[full_bit] |=> !shift_foreground_o)
    else $error("shift while buffer full");
  chk_shift_sets_full: assert property (@(posedge clk_i) disable iff (rst_i)
    next_shift |=> flags[full_bit] || init_mode)
    else $error("shift did not set full flag");
  chk_init_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    init_mode |=> flags[7:6] == 2'b00 && flags[1:0] == 2'b00)
    else $error("flags not held in init mode");
  chk_init_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    init_mode && flags[status_bit] |=> flags[5:2] == $past(flags[5:2]))
    else $error("state fields lost in init mode");
  chk_overrun_set: assert property (@(posedge clk_i) disable iff (rst_i)
    overrun_event_i && !init_mode |=> flags[overrun_bit])
    else $error("overrun not flagged");
  chk_zero_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == flags_offset && !init_mode && !dat_i[overrun_bit] && flags[overrun_bit]
    |=> flags[overrun_bit])
    else $error("zero write cleared overrun flag");
  chk_err_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    flags[overrun_bit] && enables[overrun_bit] |=> error_irq_o)
    else $error("error request missing");
  chk_wake_set: assert property (@(posedge clk_i) disable iff (rst_i)
    control[sleep_ak_bit] && control[wakeup_enable_bit] && act_sync && !act_prev && !init_mode
    |=> flags[wakeup_bit])
    else $error("wakeup not flagged");

  // Multi-step paths as sequences, so each latency is spelled out
  sequence s_pin_seen;
    (act_meta && !act_sync) ##1 (act_sync && !act_prev);
  endsequence
  sequence s_wake_armed;
    control[sleep_ak_bit] && control[wakeup_enable_bit] && !init_mode;
  endsequence
  sequence s_shift_ready;
    !flags[full_bit] && fifo_not_empty_i && msg_good_i && !init_mode;
  endsequence
  sequence s_bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_status_clear;
    wr && adr_i == flags_offset && dat_i[status_bit] && flags[status_bit] && !init_mode;
  endsequence
  chk_wake_path: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pin_seen ##0 s_wake_armed |=> flags[wakeup_bit])
    else $error("pin edge did not reach wakeup flag");
  chk_shift_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_shift_ready |=> shift_foreground_o ##1 !shift_foreground_o)
    else $error("foreground shift not a single pulse");
  chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_req |=> ack_o ##1 !ack_o)
    else $error("bus access not acknowledged once");
  chk_status_reopen: assert property (@(posedge clk_i) disable iff (rst_i)
    s_status_clear |=> !flags[status_bit] ##1 (flags[5:4] == $past(rx_target)))
    else $error("state fields did not resume after clear");

  // Requests, clears and field coding, one cycle after the cause
  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_events & irq_mask) != 3'h0 |=> irq_o)
    else $error("unmasked request did not raise irq");
  chk_rx_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    flags[full_bit] && enables[full_bit] |=> receive_irq_o)
    else $error("receive request missing");
  chk_wake_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    flags[wakeup_bit] && enables[wakeup_bit] |=> wakeup_irq_o)
    else $error("wakeup request missing");
  chk_overrun_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == flags_offset && dat_i[overrun_bit] && overrun_event_i && !init_mode
    |=> flags[overrun_bit])
    else $error("overrun clear beat a new event");
  chk_full_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == flags_offset && dat_i[full_bit] && flags[full_bit] && !init_mode
    |=> !flags[full_bit])
    else $error("full flag not cleared by one write");
  chk_fields_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == flags_offset && flags[status_bit] && !init_mode
    |=> flags[5:2] == $past(flags[5:2]))
    else $error("write changed state fields");
  chk_rx_error_code: assert property (@(posedge clk_i) disable iff (rst_i)
    !flags[status_bit] && tx_err_count_i <= busoff_limit && rx_state != st_bus_off &&
    {1'b0, rx_err_count_i} > err_limit |=> flags[5:4] == 2'b10)
    else $error("receiver error state miscoded");
  chk_tx_busoff: assert property (@(posedge clk_i) disable iff (rst_i)
    !flags[status_bit] && tx_err_count_i > busoff_limit |=> flags[3:2] == 2'b11)
    else $error("transmitter bus-off miscoded");
  chk_busoff_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    !flags[status_bit] && rx_state == st_bus_off && tx_err_count_i <= busoff_limit
    |=> flags[5:4] == 2'b00)
    else $error("receiver did not drop to ok after bus-off");
  chk_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without a request");
endmodule : can_rx_flags

// *** testbench/can_engine_model.sv ***
// Purpose: Protocol engine stand-in holding receive FIFO entries
// Assumes: Shift pulses come from the flag block on the same clock
// Notes:   Every entry is a good message; shifts are counted for the bench
`timescale 1ns/1ps
module can_engine_model (
  input  wire logic       clk_i,
  input  wire logic       push_i,
  input  wire logic       shift_i,
  output logic            not_empty_o,
  output logic            good_o,
  output logic [3:0]      shifts_o
);
  logic [3:0] entries = 4'h0;
  logic [3:0] shifted = 4'h0;
  always @(posedge clk_i) begin
    entries <= entries + {3'h0, push_i} - {3'h0, shift_i};
    if (shift_i) shifted <= shifted + 4'h1;
  end
  assign shifts_o    = shifted;
  assign not_empty_o = (entries != 4'h0);
  // Any entry present counts as a good message here
  assign good_o      = not_empty_o;
endmodule : can_engine_model

// *** testbench/can_rx_flags_tb_top.sv ***
// Purpose: Register-level checks of receiver flags and bus state
// Assumes: Classic Wishbone, one-cycle registered ack
// Notes:   Expected values come from the counter thresholds
`timescale 1ns/1ps
module can_rx_flags_tb_top;
  import can_rx_flags_pkg::*;
  `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, push = 0;
  logic bus_activity_i = 0, overrun_event_i = 0, msg_good_i, fifo_not_empty_i;
  logic [7:0] adr_i = 8'h00, rx_err_count_i = 8'h00;
  logic [3:0] sel_i = 4'hF, shifts;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [8:0] tx_err_count_i = 9'h000;
  logic ack_o, shift_foreground_o, wakeup_irq_o, error_irq_o, receive_irq_o, irq_o;
  int miscompares = 0, compares = 0;
  always #25 clk_i = ~clk_i;
  can_rx_flags u_can_rx_flags (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tx_err_count_i(tx_err_count_i), .rx_err_count_i(rx_err_count_i),
    .bus_activity_i(bus_activity_i), .overrun_event_i(overrun_event_i),
    .msg_good_i(msg_good_i), .fifo_not_empty_i(fifo_not_empty_i),
    .shift_foreground_o(shift_foreground_o), .wakeup_irq_o(wakeup_irq_o),
    .error_irq_o(error_irq_o), .receive_irq_o(receive_irq_o), .irq_o(irq_o));
  can_engine_model u_can_engine_model (.clk_i(clk_i), .push_i(push),
    .shift_i(shift_foreground_o), .not_empty_o(fifo_not_empty_i), .good_o(msg_good_i),
    .shifts_o(shifts));
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h0, d};
    // No wait limit here; a lost ack is left to the watchdog
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK("register", e & m, q & m)
  endtask : expect_reg
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  initial begin
    idle(20000);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    idle(16);
    rst_i <= 1'b0;
    expect_reg(flags_offset, 8'hFF, flags_reset);
    wr(flags_offset, 8'hFF);
    overrun_event_i <= 1'b1;
    idle(1);
    overrun_event_i <= 1'b0;
    wr(flags_offset, 8'h00);
    expect_reg(flags_offset, 8'hFF, 8'h02);
    wr(enables_offset, 8'h02);
    wr(irq_mask_offset, 8'h02);
    idle(3);
    `CHK("error_irq", 1'b1, error_irq_o)
    `CHK("irq", 1'b1, irq_o)
    wr(flags_offset, 8'h02);
    expect_reg(flags_offset, 8'h02, 8'h00);
    wr(irq_status_offset, 8'h02);
    idle(3);
    `CHK("error_irq", 1'b0, error_irq_o)
    `CHK("irq", 1'b0, irq_o)
    push <= 1'b1;
    idle(2);
    push <= 1'b0;
    wr(enables_offset, 8'h01);
    idle(4);
    `CHK("shifts", 4'h1, shifts)
    `CHK("receive_irq", 1'b1, receive_irq_o)
    expect_reg(flags_offset, 8'h01, 8'h01);
    wr(flags_offset, 8'h01);
    idle(4);
    `CHK("shifts", 4'h2, shifts)
    wr(flags_offset, 8'h01);
    idle(4);
    `CHK("shifts", 4'h2, shifts)
    expect_reg(flags_offset, 8'h01, 8'h00);
    rx_err_count_i <= 8'd97;
    idle(4);
    expect_reg(flags_offset, 8'h7C, 8'h50);
    rx_err_count_i <= 8'd128;
    idle(4);
    expect_reg(flags_offset, 8'h7C, 8'h50);
    wr(flags_offset, 8'h40);
    idle(4);
    expect_reg(flags_offset, 8'h7C, 8'h60);
    tx_err_count_i <= 9'd256;
    wr(flags_offset, 8'h40);
    idle(4);
    expect_reg(flags_offset, 8'h7C, 8'h7C);
    tx_err_count_i <= 9'd0;
    // REC stays high: bus-off exit must still show receiver ok
    wr(flags_offset, 8'h40);
    idle(4);
    expect_reg(flags_offset, 8'h7C, 8'h40);
    rx_err_count_i <= 8'd100;
    wr(flags_offset, 8'h40);
    idle(4);
    wr(control_offset, 8'h06);
    idle(3);
    expect_reg(flags_offset, 8'hFF, 8'h10);
    wr(control_offset, 8'h00);
    idle(3);
    expect_reg(flags_offset, 8'hF3, 8'h10);
    wr(enables_offset, 8'h80);
    wr(control_offset, 8'h09);
    bus_activity_i <= 1'b1;
    idle(6);
    expect_reg(flags_offset, 8'h80, 8'h80);
    `CHK("wakeup_irq", 1'b1, wakeup_irq_o)
    expect_reg(irq_status_offset, 8'h04, 8'h04);
    bus_activity_i <= 1'b0;
    expect_reg(8'h20, 8'hFF, 8'h00);
    tally_and_finish();
  end
endmodule : can_rx_flags_tb_top
